// file: include/lbi_pkg.sv
package lbi_pkg;

  // Clock and timing figures
  localparam int CLK_PERIOD_NS      = 100;
  localparam int NMI_MIN_HOLD_CYC   = 2;
  localparam int RESET_MIN_HOLD_CYC = 4;
  localparam int SYNC_STAGES        = 2;

  // Bus cycle kinds, coded as the maximum-mode cycle status
  typedef enum logic [2:0] {
    KIND_IRQ_ACK_STROBE_N    = 3'h0,
    KIND_IO_RD   = 3'h1,
    KIND_IO_WR   = 3'h2,
    KIND_HALT    = 3'h3,
    KIND_CODE    = 3'h4,
    KIND_MEM_RD  = 3'h5,
    KIND_MEM_WR  = 3'h6,
    KIND_PASSIVE = 3'h7
  } lbi_kind_t;

  // Segment codes, bit 0 is segment_status_a, bit 1 is segment_status_b
  localparam logic [1:0] SEG_ALT   = 2'h0;
  localparam logic [1:0] SEG_STACK = 2'h1;
  localparam logic [1:0] SEG_CODE  = 2'h2;
  localparam logic [1:0] SEG_DATA  = 2'h3;

  // Queue state codes
  localparam logic [1:0] QS_NOP   = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_EMPTY = 2'h2;
  localparam logic [1:0] QS_NEXT  = 2'h3;

  // Fixed values and reset values
  localparam logic [7:0]  NMI_TYPE   = 8'h02;
  localparam logic [19:0] ADDR_RST   = 20'h00000;
  localparam logic [7:0]  DATA_RST   = 8'h00;
  localparam logic [3:0]  IO_HI_ADDR = 4'h0;
  localparam logic [1:0]  GRANT_RST  = 2'h0;

  // Bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4, ST_HOLD
  } lbi_state_t;

  // Cycle decoding shared by the sequencer and its checks
  function automatic logic lbi_is_read(lbi_kind_t k);
    return (k == KIND_IO_RD) || (k == KIND_CODE) || (k == KIND_MEM_RD);
  endfunction

  function automatic logic lbi_is_write(lbi_kind_t k);
    return (k == KIND_IO_WR) || (k == KIND_MEM_WR);
  endfunction

  function automatic logic lbi_is_io(lbi_kind_t k);
    return (k == KIND_IO_RD) || (k == KIND_IO_WR);
  endfunction

endpackage

// file: hw/lbi_sync.sv
`timescale 1ns/100ps
module lbi_sync
  import lbi_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_sync_b,
  // Level in and synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage, nothing else looks at it
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// file: hw/lbi_bus_unit.sv
`timescale 1ns/100ps
// Function
// - Low address byte in first state, data on same lines afterwards
// - Shared and middle address lines float in interrupt acknowledge and hold
// - Address bits 8 to 15 stay valid through every bus state except in interrupt acknowledge cycles and hold
// - Top lines carry upper address in first state, zero for I/O
// - Two status bits give segment in use after first state
// - Read strobe low while reading, floated in hold
// - Maskable request synchronised, sampled at instruction end, masked by flag
// - Wait instruction idles while release input is high
// - Non-maskable request held two cycles, synchronised, gives type 2
// - Reset held four cycles, initialisation starts at once
// - Strap high picks minimum mode, low picks maximum mode
// - Maximum mode drives three-bit cycle status, floated in hold
// - Two active-low request/grant lines pass the bus to other masters
// - Lock output low keeps other masters off, floated in hold
// - Maximum mode reports queue state on two lines
// - Space select low for memory, high for I/O, floated in hold
// - Write strobe low during write cycles, floated in hold
// - Interrupt acknowledge strobe acts as read strobe for that cycle
// - Address latch pulse positive, never floated, latch on falling edge
// - Transceiver direction high to transmit, low to receive
// - Transceiver enable active low, floated in hold
module lbi_bus_unit
  import lbi_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Strap and handshake pins
  input  wire logic        bus_mode_strap,
  input  wire logic        ready,
  input  wire logic        maskable_irq_req,
  input  wire logic        nmi_req,
  input  wire logic        wait_release,
  input  wire logic        hold_req,
  // Core request side
  input  wire logic        req_valid,
  input  wire lbi_kind_t   req_kind,
  input  wire logic [19:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  input  wire logic [1:0]  req_seg,
  input  wire logic        req_lock,
  input  wire logic        ie_flag,
  input  wire logic        instr_last,
  input  wire logic        wait_exec,
  input  wire logic        nmi_ack,
  input  wire logic [1:0]  queue_op,
  // Core answer side
  output logic             req_ack_r,
  output logic             cycle_done_r,
  output logic [7:0]       rdata_r,
  output logic             irq_take_r,
  output logic             nmi_pend_r,
  output logic [7:0]       nmi_type_r,
  output logic             wait_idle_r,
  output logic             wait_done_r,
  // Shared and address pins
  input  wire logic [7:0]  shared_addr_data_lo_i,
  output logic [7:0]       shared_addr_data_lo_o_r,
  output logic             shared_addr_data_lo_oe_r,
  output logic [7:0]       addr_mid_byte_o_r,
  output logic             addr_mid_byte_oe_r,
  output logic [3:0]       addr_high_status_o_r,
  output logic             addr_high_status_oe_r,
  output logic             rd_n_o_r,
  output logic             rd_n_oe_r,
  output logic             ale_r,
  // Minimum mode pins
  output logic             io_mem_sel_o_r,
  output logic             wr_n_o_r,
  output logic             xcvr_direction_o_r,
  output logic             xcvr_enable_n_o_r,
  output logic             min_ctl_oe_r,
  output logic             irq_ack_strobe_n_o_r,
  output logic             irq_ack_strobe_n_oe_r,
  output logic             hold_ack_r,
  // Maximum mode pins
  output logic [2:0]       cycle_status_o_r,
  output logic             lock_n_o_r,
  output logic             max_ctl_oe_r,
  output logic [1:0]       queue_state_r,
  input  wire logic [1:0]  bus_request_grant_i,
  output logic [1:0]       bus_request_grant_o_r,
  output logic [1:0]       bus_request_grant_oe_r
);

  logic        rst_meta_r;
  logic        rst_sync_b;
  logic        strap_done_r;
  logic        mode_min_r;
  logic [2:0]  sync_q;
  logic        irq_s;
  logic        nmi_s;
  logic        wait_s;
  lbi_state_t  state_r, state_nxt;
  lbi_kind_t   kind_r, kind_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic [1:0]  seg_r, seg_nxt;
  logic        lock_r, lock_nxt;
  logic        hold_ch_r, hold_ch_nxt;
  logic        hold_fresh_r, hold_fresh_nxt;
  logic [1:0]  rq_pend_r, rq_pend_nxt;
  logic [1:0]  rq_seen;
  logic        hold_want, hold_end, grant_ch;
  logic        req_ack_nxt, done_nxt;
  logic [7:0]  rdata_nxt;
  logic        hold_n, act, t1, dat, irq_ack_strobe_n;
  logic        nmi_prev_r, nmi_seen_r, nmi_fire;

  // Reset is taken at once and released through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // Strap is caught on the first edge after release, then frozen
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      strap_done_r <= 1'b0;
      mode_min_r   <= 1'b1;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      mode_min_r   <= bus_mode_strap;
    end
  end

  // Asynchronous requests pass through two flops first
  lbi_sync #(.WIDTH(3)) u_sync (
    .sys_clk    (sys_clk),
    .rst_sync_b (rst_sync_b),
    .d          ({wait_release, nmi_req, maskable_irq_req}),
    .q          (sync_q)
  );
  assign irq_s  = sync_q[0];
  assign nmi_s  = sync_q[1];
  assign wait_s = sync_q[2];

  // One request detector per grant line; a short pulse is remembered
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rq
      assign rq_seen[gi] = !bus_request_grant_i[gi] || rq_pend_r[gi];
    end
  endgenerate

  // Lock keeps the bus from being granted away in maximum mode
  assign grant_ch  = !rq_seen[0];
  assign hold_want = strap_done_r && (mode_min_r ? hold_req :
                     (!req_lock && (|rq_seen)));
  // Own grant pulse reads back low, so the first hold cycle is ignored
  assign hold_end  = mode_min_r ? !hold_req :
                     (!hold_fresh_r && !bus_request_grant_i[hold_ch_r]);

  // Bus sequencer and next pin values
  always_comb begin
    state_nxt      = state_r;
    kind_nxt       = kind_r;
    addr_nxt       = addr_r;
    wdata_nxt      = wdata_r;
    seg_nxt        = seg_r;
    lock_nxt       = lock_r;
    hold_ch_nxt    = hold_ch_r;
    hold_fresh_nxt = 1'b0;
    req_ack_nxt    = 1'b0;
    done_nxt       = 1'b0;
    rdata_nxt      = rdata_r;
    unique case (state_r)
      ST_IDLE: begin
        if (hold_want) begin
          state_nxt      = ST_HOLD;
          hold_ch_nxt    = grant_ch;
          hold_fresh_nxt = 1'b1;
        end else if (strap_done_r && req_valid && !wait_idle_r) begin
          state_nxt   = ST_T1;
          kind_nxt    = req_kind;
          addr_nxt    = req_addr;
          wdata_nxt   = req_wdata;
          seg_nxt     = req_seg;
          lock_nxt    = req_lock;
          req_ack_nxt = 1'b1;
        end
      end
      ST_T1: state_nxt = ST_T2;
      ST_T2: state_nxt = ST_T3;
      ST_T3, ST_TW: begin
        // Halt cycles move no data, so they never wait on ready
        if (ready || kind_r == KIND_HALT) begin
          state_nxt = ST_T4;
          if (lbi_is_read(kind_r) || kind_r == KIND_IRQ_ACK_STROBE_N) begin
            rdata_nxt = shared_addr_data_lo_i;
          end
        end else begin
          state_nxt = ST_TW;
        end
      end
      ST_T4: begin
        state_nxt = ST_IDLE;
        done_nxt  = 1'b1;
      end
      ST_HOLD: if (hold_end) state_nxt = ST_IDLE;
    endcase
    // Remember request pulses that arrive while a cycle runs
    for (int i = 0; i < 2; i++) begin
      rq_pend_nxt[i] = !mode_min_r && state_r != ST_HOLD && rq_seen[i] &&
                       !(hold_fresh_nxt && hold_ch_nxt == i[0]);
    end
    hold_n = state_nxt == ST_HOLD;
    act    = state_nxt != ST_IDLE && !hold_n;
    t1     = state_nxt == ST_T1;
    dat    = act && !t1;
    irq_ack_strobe_n   = act && kind_nxt == KIND_IRQ_ACK_STROBE_N;
  end

  // Bus state and pins, all straight from flops
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r                  <= ST_IDLE;
      kind_r                   <= KIND_PASSIVE;
      addr_r                   <= ADDR_RST;
      wdata_r                  <= DATA_RST;
      seg_r                    <= SEG_ALT;
      lock_r                   <= 1'b0;
      hold_ch_r                <= 1'b0;
      hold_fresh_r             <= 1'b0;
      rq_pend_r                <= GRANT_RST;
      req_ack_r                <= 1'b0;
      cycle_done_r             <= 1'b0;
      rdata_r                  <= DATA_RST;
      shared_addr_data_lo_o_r  <= DATA_RST;
      shared_addr_data_lo_oe_r <= 1'b0;
      addr_mid_byte_o_r        <= DATA_RST;
      addr_mid_byte_oe_r       <= 1'b0;
      addr_high_status_o_r     <= IO_HI_ADDR;
      addr_high_status_oe_r    <= 1'b0;
      rd_n_o_r                 <= 1'b1;
      rd_n_oe_r                <= 1'b0;
      ale_r                    <= 1'b0;
      io_mem_sel_o_r           <= 1'b0;
      wr_n_o_r                 <= 1'b1;
      xcvr_direction_o_r       <= 1'b1;
      xcvr_enable_n_o_r        <= 1'b1;
      min_ctl_oe_r             <= 1'b0;
      irq_ack_strobe_n_o_r     <= 1'b1;
      irq_ack_strobe_n_oe_r    <= 1'b0;
      hold_ack_r               <= 1'b0;
      cycle_status_o_r         <= KIND_PASSIVE;
      lock_n_o_r               <= 1'b1;
      max_ctl_oe_r             <= 1'b0;
      queue_state_r            <= QS_NOP;
      bus_request_grant_o_r    <= GRANT_RST;
      bus_request_grant_oe_r   <= GRANT_RST;
    end else begin
      state_r      <= state_nxt;
      kind_r       <= kind_nxt;
      addr_r       <= addr_nxt;
      wdata_r      <= wdata_nxt;
      seg_r        <= seg_nxt;
      lock_r       <= lock_nxt;
      hold_ch_r    <= hold_ch_nxt;
      hold_fresh_r <= hold_fresh_nxt;
      rq_pend_r    <= rq_pend_nxt;
      req_ack_r    <= req_ack_nxt;
      cycle_done_r <= done_nxt;
      rdata_r      <= rdata_nxt;
      shared_addr_data_lo_o_r  <= t1 ? addr_nxt[7:0] : wdata_nxt;
      shared_addr_data_lo_oe_r <= !irq_ack_strobe_n &&
        (t1 || (dat && lbi_is_write(kind_nxt)));
      addr_mid_byte_o_r     <= addr_nxt[15:8];
      addr_mid_byte_oe_r    <= !hold_n && !irq_ack_strobe_n;
      addr_high_status_o_r  <= t1 ? (lbi_is_io(kind_nxt) ? IO_HI_ADDR :
        addr_nxt[19:16]) : {1'b0, ie_flag, seg_nxt};
      addr_high_status_oe_r <= !hold_n;
      rd_n_o_r              <= !(dat && lbi_is_read(kind_nxt));
      rd_n_oe_r             <= !hold_n;
      ale_r                 <= t1;
      io_mem_sel_o_r        <= act && lbi_is_io(kind_nxt);
      wr_n_o_r              <= !(dat && lbi_is_write(kind_nxt));
      xcvr_direction_o_r    <= !(act && !lbi_is_write(kind_nxt));
      xcvr_enable_n_o_r     <= !(dat && kind_nxt != KIND_HALT);
      min_ctl_oe_r          <= mode_min_r && !hold_n;
      irq_ack_strobe_n_o_r  <= !(dat && kind_nxt == KIND_IRQ_ACK_STROBE_N);
      irq_ack_strobe_n_oe_r <= mode_min_r;
      hold_ack_r            <= mode_min_r && hold_n;
      cycle_status_o_r      <= (act && (t1 || state_nxt == ST_T2)) ?
                               kind_nxt : KIND_PASSIVE;
      lock_n_o_r            <= !(act && lock_nxt);
      max_ctl_oe_r          <= !mode_min_r && !hold_n;
      queue_state_r         <= mode_min_r ? QS_NOP : queue_op;
      bus_request_grant_o_r <= GRANT_RST;
      // Grant is a one-cycle low pulse on the chosen line
      bus_request_grant_oe_r <= (!mode_min_r && hold_fresh_nxt) ?
        (hold_ch_nxt ? 2'h2 : 2'h1) : GRANT_RST;
    end
  end

  // NMI fires once per level held two synchronised cycles
  assign nmi_fire = nmi_s && nmi_prev_r && !nmi_seen_r;

  // Interrupt sampling and wait idling
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      nmi_prev_r  <= 1'b0;
      nmi_seen_r  <= 1'b0;
      nmi_pend_r  <= 1'b0;
      nmi_type_r  <= NMI_TYPE;
      irq_take_r  <= 1'b0;
      wait_idle_r <= 1'b0;
      wait_done_r <= 1'b0;
    end else begin
      nmi_prev_r  <= nmi_s;
      nmi_seen_r  <= nmi_s && (nmi_seen_r || nmi_fire);
      // A new event beats an acknowledge in the same cycle
      nmi_pend_r  <= nmi_fire || (nmi_pend_r && !nmi_ack);
      nmi_type_r  <= NMI_TYPE;
      irq_take_r  <= instr_last && ie_flag && irq_s;
      wait_idle_r <= wait_exec && wait_s;
      wait_done_r <= wait_exec && !wait_s && !wait_done_r;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_b);

  a_addr_lo_t1:   assert property (ale_r |-> shared_addr_data_lo_oe_r ==
    (kind_r != KIND_IRQ_ACK_STROBE_N) && shared_addr_data_lo_o_r == addr_r[7:0])
    else $error("low address byte missing in first state");
  a_float_hold:   assert property (state_r == ST_HOLD |-> !rd_n_oe_r &&
    !shared_addr_data_lo_oe_r && !addr_mid_byte_oe_r)
    else $error("bus lines driven during hold");
  a_mid_valid:    assert property (state_r != ST_HOLD &&
    kind_r != KIND_IRQ_ACK_STROBE_N && state_r != ST_IDLE |->
    addr_mid_byte_oe_r && addr_mid_byte_o_r == addr_r[15:8])
    else $error("middle address not valid");
  a_io_high_zero: assert property (ale_r && lbi_is_io(kind_r) |->
    addr_high_status_o_r == IO_HI_ADDR)
    else $error("upper address not low for io");
  a_seg_status:   assert property (ale_r |=>
    addr_high_status_o_r[1:0] == seg_r)
    else $error("segment status wrong");
  a_rd_strobe:    assert property (ale_r && lbi_is_read(kind_r) |=>
    !rd_n_o_r [*2])
    else $error("read strobe not asserted");
  a_wait_ready:   assert property (state_r == ST_T3 && !ready &&
    kind_r != KIND_HALT |=> state_r == ST_TW && !cycle_done_r)
    else $error("wait state not inserted");
  a_done_ready:   assert property (state_r == ST_TW && ready |=>
    ##1 cycle_done_r)
    else $error("cycle not finished after ready");
  a_irq_masked:   assert property (irq_take_r |-> $past(ie_flag) &&
    $past(instr_last))
    else $error("masked interrupt taken");
  a_nmi_width:    assert property ($rose(nmi_pend_r) |->
    $past(nmi_s, 1) && $past(nmi_s, 2))
    else $error("nmi taken on short pulse");
  a_cycle_status: assert property (ale_r && !mode_min_r |->
    max_ctl_oe_r && cycle_status_o_r == kind_r)
    else $error("cycle status wrong in first state");
  a_ale_single:   assert property (ale_r |=> !ale_r)
    else $error("latch pulse longer than one cycle");
  a_wr_strobe:    assert property (ale_r && lbi_is_write(kind_r) |=>
    !wr_n_o_r && shared_addr_data_lo_oe_r)
    else $error("write strobe or data missing");
  a_wait_blocks:  assert property (wait_idle_r |=> !req_ack_r)
    else $error("bus cycle started while wait idling");

  c_wait_read:  cover property (state_r == ST_TW ##1 state_r == ST_T4);
  c_hold_min:   cover property (hold_ack_r ##1 !hold_ack_r);
  c_grant_max:  cover property (|bus_request_grant_oe_r);
  c_nmi_taken:  cover property ($rose(nmi_pend_r));

endmodule

// file: dv/lbi_mem_model.sv
`timescale 1ns/100ps
module lbi_mem_model
  import lbi_pkg::*;
(
  // Clock and stall setting
  input  wire logic       sys_clk,
  input  wire logic [3:0] wait_cfg,
  // Bus pins seen from the device
  input  wire logic       ale,
  input  wire logic [7:0] ad_o,
  input  wire logic       ad_oe,
  input  wire logic       rd_act,
  input  wire logic       irq_ack_strobe_n_act,
  // Answer to the device
  output logic      [7:0] ad_i,
  output logic            ready
);
  logic [7:0] lat_r;
  logic [4:0] cnt_r;

  // Quiet bus before the first cycle
  initial begin
    lat_r = 8'h00;
    cnt_r = 5'h00;
    ad_i  = 8'h00;
    ready = 1'b1;
  end

  // Latch the low byte while the pulse is high, ready after wait_cfg states
  always @(negedge sys_clk) begin
    if (ale) begin
      lat_r <= ad_oe ? ad_o : 8'h00;
      cnt_r <= {1'b0, wait_cfg} + 5'h01;
      ready <= 1'b0;
    end else begin
      ready <= (cnt_r == 5'h00);
      if (cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
    // Data only under a strobe; elsewhere it toggles so nothing stale passes
    if (rd_act || irq_ack_strobe_n_act) begin
      ad_i <= lat_r ^ 8'hA5;
    end else begin
      ad_i <= ~ad_i;
    end
  end
endmodule

// file: dv/tb_cpu_local_bus_interface.sv
`timescale 1ns/100ps
module tb_cpu_local_bus_interface;
  import lbi_pkg::*;
  // Stimulus
  logic        sys_clk, rst_b, strap, ready, irq, nmi, wrel, hold_req;
  logic        req_valid, req_lock, ie_flag, instr_last, wait_exec, nmi_ack;
  lbi_kind_t   req_kind;
  logic [19:0] req_addr;
  logic [7:0]  req_wdata, ad_i;
  logic [3:0]  wait_cfg;
  logic [1:0]  req_seg, queue_op, rg_n, rg_i;
  int          bad_count, cmp_count, cyc;
  // Observed outputs
  logic        ack, done, irq_take, nmi_pend, widle, wdone, ad_oe, mid_oe;
  logic        hi_oe, rd_n, rd_oe, ale, iom, wr_n, dir, en_n, min_oe;
  logic        irq_ack_strobe_n_n, irq_ack_strobe_n_oe, hold_ack, lock_n, max_oe;
  logic [7:0]  rdata, nmi_type, ad_o, mid;
  logic [3:0]  hi;
  logic [2:0]  cst;
  logic [1:0]  qs, rg_o, rg_oe;

  // Request/grant wire: low if the requester or the device pulls it
  assign rg_i = rg_n & ~(rg_oe & ~rg_o);

  lbi_bus_unit i_lbi_bus_unit (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus_mode_strap(strap),
    .ready(ready), .maskable_irq_req(irq), .nmi_req(nmi),
    .wait_release(wrel), .hold_req(hold_req), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_seg(req_seg), .req_lock(req_lock), .ie_flag(ie_flag),
    .instr_last(instr_last), .wait_exec(wait_exec), .nmi_ack(nmi_ack),
    .queue_op(queue_op), .req_ack_r(ack), .cycle_done_r(done),
    .rdata_r(rdata), .irq_take_r(irq_take), .nmi_pend_r(nmi_pend),
    .nmi_type_r(nmi_type), .wait_idle_r(widle), .wait_done_r(wdone),
    .shared_addr_data_lo_i(ad_i), .shared_addr_data_lo_o_r(ad_o),
    .shared_addr_data_lo_oe_r(ad_oe), .addr_mid_byte_o_r(mid),
    .addr_mid_byte_oe_r(mid_oe), .addr_high_status_o_r(hi),
    .addr_high_status_oe_r(hi_oe), .rd_n_o_r(rd_n), .rd_n_oe_r(rd_oe),
    .ale_r(ale), .io_mem_sel_o_r(iom), .wr_n_o_r(wr_n),
    .xcvr_direction_o_r(dir), .xcvr_enable_n_o_r(en_n),
    .min_ctl_oe_r(min_oe), .irq_ack_strobe_n_o_r(irq_ack_strobe_n_n),
    .irq_ack_strobe_n_oe_r(irq_ack_strobe_n_oe), .hold_ack_r(hold_ack),
    .cycle_status_o_r(cst), .lock_n_o_r(lock_n), .max_ctl_oe_r(max_oe),
    .queue_state_r(qs), .bus_request_grant_i(rg_i),
    .bus_request_grant_o_r(rg_o), .bus_request_grant_oe_r(rg_oe));

  lbi_mem_model i_lbi_mem_model (
    .sys_clk(sys_clk), .wait_cfg(wait_cfg), .ale(ale), .ad_o(ad_o),
    .ad_oe(ad_oe), .rd_act(rd_oe & ~rd_n), .irq_ack_strobe_n_act(irq_ack_strobe_n_oe & ~irq_ack_strobe_n_n),
    .ad_i(ad_i), .ready(ready));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(string nm, logic [19:0] exp, logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hung handshakes end up in the report instead of spinning
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  function automatic logic pick(int s);
    case (s)
      0: return irq_take;
      1: return nmi_pend;
      2: return widle;
      3: return wdone;
      4: return rg_oe[0];
      5: return ale;
      default: return done;
    endcase
  endfunction

  // Bounded wait for one flag; n reaches lim if it never came
  task automatic poll(int s, int lim, output int n);
    n = 0;
    while (pick(s) !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic do_reset(logic s);
    @(negedge sys_clk);
    rst_b = 1'b0;
    strap = s;
    repeat (5) @(negedge sys_clk);
    chk("ale in reset", 0, ale);
    chk("oe reset", 0, {ad_oe, mid_oe, hi_oe, rd_oe, min_oe, max_oe});
    chk("status in reset", 7, cst);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic run_cycle(lbi_kind_t k, logic [19:0] a, logic [7:0] d,
                           logic [1:0] sg, logic [3:0] w);
    int  n;
    logic rdk, wrk, iok, ik;
    rdk = (k == KIND_IO_RD) || (k == KIND_CODE) || (k == KIND_MEM_RD);
    wrk = (k == KIND_IO_WR) || (k == KIND_MEM_WR);
    iok = (k == KIND_IO_RD) || (k == KIND_IO_WR);
    ik = (k == KIND_IRQ_ACK_STROBE_N);
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    req_seg = sg;
    wait_cfg = w;
    req_valid = 1'b1;
    poll(5, 8, n);
    req_valid = 1'b0;
    chk("req ack", 1, ack);
    chk("ad oe T1", !ik, ad_oe);
    if (!ik) chk("ad addr T1", a[7:0], ad_o);
    chk("mid oe", !ik, mid_oe);
    if (!ik) chk("mid T1", a[15:8], mid);
    chk("high T1", iok ? 4'h0 : a[19:16], hi);
    if (!strap) chk("status T1", k, cst);
    @(negedge sys_clk);
    chk("status T2", {1'b0, ie_flag, sg}, hi);
    if (!ik) chk("mid T2", a[15:8], mid);
    if (k != KIND_HALT) chk("ad oe T2", wrk, ad_oe);
    if (wrk) chk("ad data T2", d, ad_o);
    chk("read strobe", !rdk, rd_n);
    if (strap) begin
      chk("space sel", iok, iom);
      chk("write strobe", !wrk, wr_n);
      chk("irq_ack_strobe_n strobe", !ik, irq_ack_strobe_n_n);
      chk("irq_ack_strobe_n oe", 1, irq_ack_strobe_n_oe);
      chk("direction", wrk, dir);
      if (rdk || wrk) chk("xcvr enable", 0, en_n);
    end else begin
      chk("status T2", k, cst);
      chk("lock", !req_lock, lock_n);
    end
    poll(6, 20, n);
    chk("cycle length", (k == KIND_HALT) ? 3 : 3 + w, n);
    if (rdk || (ik && strap)) begin
      chk("read data", (ik ? 8'h00 : a[7:0]) ^ 8'hA5, rdata);
    end
  endtask

  // Every kind but passive back to back, then reads with growing stalls
  task automatic t_cycles();
    for (int i = 0; i < 7; i++) begin
      ie_flag = i[0];
      req_lock = i[0];
      run_cycle(lbi_kind_t'(i), 20'h9B000 + i * 20'h01111, 8'h3C + i[7:0],
                i[1:0], 4'h0);
    end
    for (int i = 0; i < 4; i++) begin
      run_cycle(KIND_MEM_RD, 20'hA5C30 + i, 8'h00, i[1:0], i[3:0]);
    end
    req_lock = 1'b0;
  endtask

  task automatic t_hold();
    hold_req = 1'b1;
    req_valid = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("hold ack", 1, hold_ack);
    chk("hold float", 0, {ad_oe, mid_oe, hi_oe, rd_oe, min_oe});
    chk("ale driven", 0, ale);
    chk("no take in hold", 0, ack);
    req_valid = 1'b0;
    hold_req = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("hold over", 0, hold_ack);
  endtask

  task automatic t_irq();
    int n;
    ie_flag = 1'b1;
    instr_last = 1'b1;
    irq = 1'b1;
    poll(0, 8, n);
    chk("irq taken", 1, n < 8);
    ie_flag = 1'b0;
    repeat (2) @(negedge sys_clk);
    poll(0, 6, n);
    chk("irq masked", 0, n < 6);
    ie_flag = 1'b1;
    instr_last = 1'b0;
    repeat (2) @(negedge sys_clk);
    poll(0, 6, n);
    chk("irq mid instr", 0, n < 6);
    irq = 1'b0;
    ie_flag = 1'b0;
  endtask

  task automatic t_nmi();
    int n;
    nmi = 1'b1;
    repeat (NMI_MIN_HOLD_CYC) @(negedge sys_clk);
    nmi = 1'b0;
    poll(1, 6, n);
    chk("nmi pending", 1, n < 6);
    chk("nmi type", 8'h02, nmi_type);
    nmi_ack = 1'b1;
    @(negedge sys_clk);
    nmi_ack = 1'b0;
    @(negedge sys_clk);
    chk("nmi cleared", 0, nmi_pend);
  endtask

  task automatic t_wait();
    int n;
    wait_exec = 1'b1;
    wrel = 1'b1;
    poll(2, 6, n);
    chk("wait idle", 1, n < 6);
    repeat (3) @(negedge sys_clk);
    chk("still idle", 1, widle);
    wrel = 1'b0;
    poll(3, 6, n);
    chk("wait done", 1, n < 6);
    wait_exec = 1'b0;
    @(negedge sys_clk);
    chk("idle left", 0, widle);
  endtask

  task automatic t_max();
    int n;
    do_reset(1'b0);
    chk("min pins float", 0, {min_oe, irq_ack_strobe_n_oe});
    chk("max pins drive", 1, max_oe);
    chk("passive", 7, cst);
    for (int i = 0; i < 4; i++) begin
      queue_op = i[1:0];
      repeat (2) @(negedge sys_clk);
      chk("queue state", i[1:0], qs);
    end
    t_cycles();
    // Requester pulses line 0 for one cycle, then again to take it back
    rg_n = 2'b10;
    @(negedge sys_clk);
    rg_n = 2'b11;
    poll(4, 4, n);
    chk("grant pulse", 1, n < 4);
    chk("grant level", 0, rg_o);
    @(negedge sys_clk);
    chk("float granted", 0, {max_oe, ad_oe, hi_oe, rd_oe});
    rg_n = 2'b10;
    @(negedge sys_clk);
    rg_n = 2'b11;
    repeat (3) @(negedge sys_clk);
    chk("bus back", 1, max_oe);
  endtask

  // Main sequence, every input given a value at time zero
  initial begin
    {rst_b, irq, nmi, wrel, hold_req, req_valid, req_lock} = 7'h00;
    {ie_flag, instr_last, wait_exec, nmi_ack} = 4'h0;
    strap = 1'b1;
    req_kind = KIND_PASSIVE;
    req_addr = 20'h00000;
    req_wdata = 8'h00;
    req_seg = 2'h0;
    queue_op = 2'h0;
    wait_cfg = 4'h0;
    rg_n = 2'h3;
    do_reset(1'b1);
    t_cycles();
    t_hold();
    t_irq();
    t_nmi();
    t_wait();
    t_max();
    tally_and_finish();
  end
endmodule
